// ### src/tplu_pkg.sv
// Constants, field layouts and carrier types of the touch probe latch unit
package tplu_pkg;

  // ************************************************************
  // Object indices of the readable results
  // ************************************************************
  localparam logic [15:0] IDX_LATCH_STATUS   = 16'h60b9;
  localparam logic [15:0] IDX_P1_RISE_POS    = 16'h60ba;
  localparam logic [15:0] IDX_P1_FALL_POS    = 16'h60bb;
  localparam logic [15:0] IDX_P2_RISE_POS    = 16'h60bc;
  localparam logic [15:0] IDX_P2_FALL_POS    = 16'h60bd;
  localparam logic [15:0] IDX_P1_RISE_COUNT  = 16'h60d5;

  // ************************************************************
  // Widths and reset values
  // ************************************************************
  localparam int          CTRL_W             = 16;
  localparam int          STATUS_W           = 16;
  localparam int          POS_W              = 32;
  localparam int          COUNT_W            = 16;
  localparam int          NUM_PROBES         = 2;
  localparam logic [15:0] STATUS_RESET       = 16'h0000;
  localparam logic [31:0] POS_RESET          = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET        = 16'h0000;
  localparam logic [15:0] COUNT_STEP         = 16'h0001;
  localparam logic [31:0] RDATA_IDLE         = 32'h0000_0000;

  // ************************************************************
  // Field positions inside one probe's byte (probe 2 sits 8 above)
  // ************************************************************
  localparam int          PROBE_FIELD_STRIDE = 8;
  localparam int          CTRL_ENABLE_BIT    = 0;
  localparam int          CTRL_MODE_BIT      = 1;
  localparam int          CTRL_SELECT_BIT    = 2;
  localparam int          CTRL_RISE_EN_BIT   = 4;
  localparam int          CTRL_FALL_EN_BIT   = 5;
  localparam int          STAT_ENABLE_BIT    = 0;
  localparam int          STAT_RISE_BIT      = 1;
  localparam int          STAT_FALL_BIT      = 2;

  // Per-probe settings taken from the probe control word
  typedef struct packed {
    logic enable;
    logic continuous;
    logic use_index;
    logic rise_en;
    logic fall_en;
  } tplu_probe_cfg_t;

  // Per-probe latch results
  typedef struct packed {
    logic                    rise_flag;
    logic                    fall_flag;
    logic signed [POS_W-1:0] rise_pos;
    logic signed [POS_W-1:0] fall_pos;
  } tplu_probe_result_t;

endpackage : tplu_pkg

// ### src/tplu_touch_probe_latch_unit.sv
// Touch probe latch unit: edge capture of position feedback on two probes
//
// Functional notes
// - Status bit 1 set on latched probe 1 rising edge, bit 2 on falling edge.
// - Status bit 9 set on latched probe 2 rising edge, bit 10 on falling edge.
// - Probe 1 rising latch stores signed 32-bit position feedback in its register.
// - Probe 1 falling latch stores signed 32-bit position feedback in its register.
// - Probe 2 rising latch stores signed 32-bit position feedback in its register.
// - Probe 2 falling latch stores signed 32-bit position feedback in its register.
// - Unsigned 16-bit count of probe 1 rising latches, from zero, read only.
// - Single mode latches first valid trigger after arming; continuous latches every one.
// - Select bit zero triggers from probe input, one from encoder index pulse.
`timescale 1ns/1ps

module tplu_touch_probe_latch_unit
(
  input  wire logic                                core_clk_i,
  input  wire logic                                rst_i,
  input  wire logic [tplu_pkg::CTRL_W-1:0]         probe_ctrl_i,
  input  wire logic                                probe1_pin_i,
  input  wire logic                                probe2_pin_i,
  input  wire logic                                index_pulse_i,
  input  wire logic signed [tplu_pkg::POS_W-1:0]   pos_feedback_i,
  input  wire logic                                obj_rd_i,
  input  wire logic [15:0]                         obj_index_i,
  output logic [tplu_pkg::POS_W-1:0]               obj_rdata_o,
  output logic                                     obj_valid_o,
  output logic                                     obj_error_o,
  output logic [tplu_pkg::STATUS_W-1:0]            latch_status_o,
  output logic [tplu_pkg::COUNT_W-1:0]             p1_rise_count_o
);
  import tplu_pkg::*;

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Pull one probe's settings out of the control word
  function automatic tplu_probe_cfg_t decode_cfg(input logic [CTRL_W-1:0] ctrl, input int probe);
    tplu_probe_cfg_t cfg;
    int              base;
    base           = probe * PROBE_FIELD_STRIDE;
    cfg.enable     = ctrl[base + CTRL_ENABLE_BIT];
    cfg.continuous = ctrl[base + CTRL_MODE_BIT];
    cfg.use_index  = ctrl[base + CTRL_SELECT_BIT];
    cfg.rise_en    = ctrl[base + CTRL_RISE_EN_BIT];
    cfg.fall_en    = ctrl[base + CTRL_FALL_EN_BIT];
    return cfg;
  endfunction : decode_cfg

  // Decide whether one edge type latches in this cycle
  function automatic logic edge_hit(input logic enable, input logic edge_en, input logic edge_seen,
                                    input logic continuous, input logic already);
    return enable & edge_en & edge_seen & (continuous | ~already);
  endfunction : edge_hit

  // ************************************************************
  // Pin synchronisers and edge detection
  // ************************************************************
  localparam int NUM_PINS = 3;
  localparam int PIN_IDX  = 2;

  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_meta;
  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] pin_prev;
  logic [NUM_PINS-1:0] pin_rise;
  logic [NUM_PINS-1:0] pin_fall;

  assign pin_raw = {index_pulse_i, probe2_pin_i, probe1_pin_i};

  // Two stages against metastability, a third stage only for edge detection
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Edges are taken from the settled stages only
  assign pin_rise = pin_sync & ~pin_prev;
  assign pin_fall = ~pin_sync & pin_prev;

  // ************************************************************
  // Per-probe latch logic
  // ************************************************************
  tplu_probe_cfg_t     cfg      [NUM_PROBES];
  tplu_probe_result_t  result   [NUM_PROBES];
  tplu_probe_result_t  next_result [NUM_PROBES];
  logic [NUM_PROBES-1:0] en_prev;
  logic [NUM_PROBES-1:0] rise_hit;
  logic [NUM_PROBES-1:0] fall_hit;
  logic [NUM_PROBES-1:0] trig_rise;
  logic [NUM_PROBES-1:0] trig_fall;

  genvar g;
  generate
    for (g = 0; g < NUM_PROBES; g++)
    begin : g_probe
      logic arm;

      assign cfg[g] = decode_cfg(probe_ctrl_i, g);

      // Edge source is chosen after edge detection, so flipping the select
      // bit never fabricates an edge out of two differing levels
      assign trig_rise[g] = cfg[g].use_index ? pin_rise[PIN_IDX] : pin_rise[g];
      assign trig_fall[g] = cfg[g].use_index ? pin_fall[PIN_IDX] : pin_fall[g];

      // Arming happens on the cycle the probe becomes enabled
      assign arm = cfg[g].enable & ~en_prev[g];

      assign rise_hit[g] = edge_hit(cfg[g].enable, cfg[g].rise_en, trig_rise[g],
                                    cfg[g].continuous, result[g].rise_flag);
      assign fall_hit[g] = edge_hit(cfg[g].enable, cfg[g].fall_en, trig_fall[g],
                                    cfg[g].continuous, result[g].fall_flag);

      // Next flags and captured positions
      always_comb
      begin
        next_result[g] = result[g];
        if (!cfg[g].enable)
        begin
          // A disabled probe reports nothing latched; positions are kept
          next_result[g].rise_flag = 1'b0;
          next_result[g].fall_flag = 1'b0;
        end
        else
        begin
          if (arm)
          begin
            // Fresh arming forgets earlier latches; an edge in the same
            // cycle still latches below, so no event is lost
            next_result[g].rise_flag = 1'b0;
            next_result[g].fall_flag = 1'b0;
          end
          if (rise_hit[g])
          begin
            next_result[g].rise_flag = 1'b1;
            next_result[g].rise_pos  = pos_feedback_i;
          end
          if (fall_hit[g])
          begin
            next_result[g].fall_flag = 1'b1;
            next_result[g].fall_pos  = pos_feedback_i;
          end
        end
      end

      // Result and arming registers
      always_ff @(posedge core_clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          result[g].rise_flag <= 1'b0;
          result[g].fall_flag <= 1'b0;
          result[g].rise_pos  <= POS_RESET;
          result[g].fall_pos  <= POS_RESET;
          en_prev[g]          <= 1'b0;
        end
        else
        begin
          result[g]  <= next_result[g];
          en_prev[g] <= cfg[g].enable;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Probe 1 rising edge counter
  // ************************************************************
  logic [COUNT_W-1:0] p1_rise_count;
  logic [COUNT_W-1:0] next_p1_rise_count;

  // Wraps at the top of its range; the master has no way to write it
  always_comb
  begin
    next_p1_rise_count = p1_rise_count;
    if (rise_hit[0])
    begin
      next_p1_rise_count = p1_rise_count + COUNT_STEP;
    end
  end

  // Counter register
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      p1_rise_count <= COUNT_RESET;
    end
    else
    begin
      p1_rise_count <= next_p1_rise_count;
    end
  end

  assign p1_rise_count_o = p1_rise_count;

  // ************************************************************
  // Status word
  // ************************************************************
  logic [STATUS_W-1:0] status_word;

  // Enable mirrors follow the control word directly
  always_comb
  begin
    status_word = STATUS_RESET;
    for (int p = 0; p < NUM_PROBES; p++)
    begin
      status_word[p*PROBE_FIELD_STRIDE + STAT_ENABLE_BIT] = cfg[p].enable;
      status_word[p*PROBE_FIELD_STRIDE + STAT_RISE_BIT]   = result[p].rise_flag;
      status_word[p*PROBE_FIELD_STRIDE + STAT_FALL_BIT]   = result[p].fall_flag;
    end
  end

  // Registered copy keeps the output free of control-word glitches
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      latch_status_o <= STATUS_RESET;
    end
    else
    begin
      latch_status_o <= status_word;
    end
  end

  // ************************************************************
  // Object read port
  // ************************************************************
  logic [POS_W-1:0] next_rdata;
  logic             next_valid;
  logic             next_error;

  // Index decode; unknown indices answer with zero data and an error
  always_comb
  begin
    next_rdata = RDATA_IDLE;
    next_valid = obj_rd_i;
    next_error = 1'b0;
    if (!obj_rd_i)
    begin
      next_valid = 1'b0;
    end
    else if (obj_index_i == IDX_LATCH_STATUS)
    begin
      next_rdata = {{(POS_W-STATUS_W){1'b0}}, status_word};
    end
    else if (obj_index_i == IDX_P1_RISE_POS)
    begin
      next_rdata = result[0].rise_pos;
    end
    else if (obj_index_i == IDX_P1_FALL_POS)
    begin
      next_rdata = result[0].fall_pos;
    end
    else if (obj_index_i == IDX_P2_RISE_POS)
    begin
      next_rdata = result[1].rise_pos;
    end
    else if (obj_index_i == IDX_P2_FALL_POS)
    begin
      next_rdata = result[1].fall_pos;
    end
    else if (obj_index_i == IDX_P1_RISE_COUNT)
    begin
      next_rdata = {{(POS_W-COUNT_W){1'b0}}, p1_rise_count};
    end
    else
    begin
      next_error = 1'b1;
    end
  end

  // Read answer registers
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      obj_rdata_o <= RDATA_IDLE;
      obj_valid_o <= 1'b0;
      obj_error_o <= 1'b0;
    end
    else
    begin
      obj_rdata_o <= next_rdata;
      obj_valid_o <= next_valid;
      obj_error_o <= next_error;
    end
  end

endmodule : tplu_touch_probe_latch_unit

// ### test/tplu_latch_monitor.sv
// Port checker of the touch probe latch unit
`timescale 1ns/1ps
module tplu_latch_monitor
(
  input wire logic                             core_clk_i,
  input wire logic                             rst_i,
  input wire logic [tplu_pkg::CTRL_W-1:0]      probe_ctrl_i,
  input wire logic                             probe1_pin_i,
  input wire logic                             probe2_pin_i,
  input wire logic                             index_pulse_i,
  input wire logic signed [tplu_pkg::POS_W-1:0] pos_feedback_i,
  input wire logic                             obj_rd_i,
  input wire logic [15:0]                      obj_index_i,
  input wire logic [tplu_pkg::POS_W-1:0]       obj_rdata_o,
  input wire logic                             obj_valid_o,
  input wire logic                             obj_error_o,
  input wire logic [tplu_pkg::STATUS_W-1:0]    latch_status_o,
  input wire logic [tplu_pkg::COUNT_W-1:0]     p1_rise_count_o
);
  import tplu_pkg::*;
  // ****
  // Assertions, all in the core clock domain
  // ****
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  property p_rd_answer;
    obj_rd_i |=> obj_valid_o;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_bad_index;
    obj_rd_i && obj_index_i == 16'h60be |=> obj_error_o && obj_rdata_o == 32'h0;
  endproperty
  a_bad_index: assert property (p_bad_index) else $error("unknown index not refused");
  property p_rsv_zero;
    (latch_status_o & 16'hf8f8) == 16'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("unused status bit set");
  // Guard skips the two edges whose past still lies inside reset
  property p_en1;
    !$past(rst_i) && !$past(rst_i, 2) |-> latch_status_o[0] == $past(probe_ctrl_i[0]);
  endproperty
  a_en1: assert property (p_en1) else $error("probe 1 enable not mirrored");
  property p_en2;
    !$past(rst_i) && !$past(rst_i, 2) |-> latch_status_o[8] == $past(probe_ctrl_i[8]);
  endproperty
  a_en2: assert property (p_en2) else $error("probe 2 enable not mirrored");
  property p_fl1_clear;
    !probe_ctrl_i[0] [*2] |=> latch_status_o[2:1] == 2'b00;
  endproperty
  a_fl1_clear: assert property (p_fl1_clear) else $error("probe 1 flag while disabled");
  property p_fl2_clear;
    !probe_ctrl_i[8] [*2] |=> latch_status_o[10:9] == 2'b00;
  endproperty
  a_fl2_clear: assert property (p_fl2_clear) else $error("probe 2 flag while disabled");
  property p_cnt_step;
    p1_rise_count_o != $past(p1_rise_count_o) |-> p1_rise_count_o == 16'($past(p1_rise_count_o) + 16'h1);
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("count moved by other than one");
  property p_cnt_flag;
    p1_rise_count_o != $past(p1_rise_count_o) |=> latch_status_o[1];
  endproperty
  a_cnt_flag: assert property (p_cnt_flag) else $error("count without rise flag");
  c_error: cover property (obj_valid_o && obj_error_o);
  c_count: cover property (p1_rise_count_o != $past(p1_rise_count_o));
  c_p2_fall: cover property (latch_status_o[10]);
endmodule : tplu_latch_monitor

bind tplu_touch_probe_latch_unit tplu_latch_monitor tplu_latch_monitor_inst (.core_clk_i, .rst_i, .probe_ctrl_i,
  .probe1_pin_i, .probe2_pin_i, .index_pulse_i, .pos_feedback_i, .obj_rd_i, .obj_index_i, .obj_rdata_o,
  .obj_valid_o, .obj_error_o, .latch_status_o, .p1_rise_count_o);

// ### test/tplu_probe_model.sv
// Sensor model: probe switches and encoder index, levels launched on the clock
`timescale 1ns/1ps
module tplu_probe_model
(
  input  wire logic       core_clk_i,
  input  wire logic [2:0] level_i,
  output logic            probe1_pin_o,
  output logic            probe2_pin_o,
  output logic            index_pulse_o
);
  // Levels change at an edge and then hold for as long as the bench asks
  always_ff @(posedge core_clk_i)
  begin
    {index_pulse_o, probe2_pin_o, probe1_pin_o} <= level_i;
  end
endmodule : tplu_probe_model

// ### test/tb_top.sv
// Self-checking bench of the touch probe latch unit
`timescale 1ns/1ps
module tb_top;
  import tplu_pkg::*;
  // ****
  // Signals and expected state
  // ****
  logic               core_clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic [15:0]        probe_ctrl_i = '0;
  logic [2:0]         lvl = '0;
  logic [2:0]         lv = '0;
  logic               p1_pin, p2_pin, idx_pin;
  logic signed [31:0] pos_feedback_i = '0;
  logic               obj_rd_i = 1'b0;
  logic [15:0]        obj_index_i = '0;
  logic [31:0]        obj_rdata_o;
  logic               obj_valid_o, obj_error_o;
  logic [15:0]        latch_status_o, p1_rise_count_o;
  logic [15:0]        es = '0;
  logic [15:0]        ecnt = '0;
  logic [31:0]        epos [4] = '{default: '0};
  int                 miscompares = 0;
  int                 num_checks = 0;
  localparam logic [15:0] IDX [6] = '{IDX_LATCH_STATUS, IDX_P1_RISE_POS, IDX_P1_FALL_POS, IDX_P2_RISE_POS,
                                      IDX_P2_FALL_POS, IDX_P1_RISE_COUNT};
  localparam logic [15:0] CTAB [6] = '{16'h3131, 16'h3333, 16'h3737, 16'h1521, 16'h0000, 16'h0033};
  always #2.5 core_clk_i = ~core_clk_i;
  tplu_probe_model tplu_probe_model_inst (.core_clk_i(core_clk_i), .level_i(lvl), .probe1_pin_o(p1_pin),
    .probe2_pin_o(p2_pin), .index_pulse_o(idx_pin));
  tplu_touch_probe_latch_unit tplu_touch_probe_latch_unit_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .probe_ctrl_i(probe_ctrl_i), .probe1_pin_i(p1_pin), .probe2_pin_i(p2_pin), .index_pulse_i(idx_pin),
    .pos_feedback_i(pos_feedback_i), .obj_rd_i(obj_rd_i), .obj_index_i(obj_index_i), .obj_rdata_o(obj_rdata_o),
    .obj_valid_o(obj_valid_o), .obj_error_o(obj_error_o), .latch_status_o(latch_status_o),
    .p1_rise_count_o(p1_rise_count_o));
  // ****
  // Tasks; each starts and ends 1 ns after a rising edge
  // ****
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Read held for one edge, dropped after it so no step assigns it twice
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic err);
    obj_rd_i = 1'b1;
    obj_index_i = idx;
    @(posedge core_clk_i);
    #1;
    chk("obj_valid_o", 32'h1, {31'h0, obj_valid_o});
    chk("obj_error_o", {31'h0, err}, {31'h0, obj_error_o});
    chk("obj_rdata_o", exp, obj_rdata_o);
    obj_rd_i = 1'b0;
    @(posedge core_clk_i);
    #1;
  endtask : rd
  task automatic check_all();
    rd(IDX[0], {16'h0, es}, 1'b0);
    for (int i = 0; i < 4; i++)
      rd(IDX[i+1], epos[i], 1'b0);
    rd(IDX[5], {16'h0, ecnt}, 1'b0);
    chk("latch_status_o", {16'h0, es}, {16'h0, latch_status_o});
    chk("p1_rise_count_o", {16'h0, ecnt}, {16'h0, p1_rise_count_o});
  endtask : check_all
  // Disable or arming clears both flags; positions are kept
  task automatic setc(input logic [15:0] c);
    for (int n = 0; n < 2; n++)
    begin
      if (!c[n*8] || !probe_ctrl_i[n*8])
        es[n*8+1 +: 2] = 2'b00;
      es[n*8] = c[n*8];
    end
    probe_ctrl_i = c;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask : setc
  // New sensor levels; the edge each probe sees comes from its chosen source
  task automatic drive(input logic [2:0] l);
    logic [31:0] p;
    logic [7:0]  c;
    logic        o, w;
    p = $urandom();
    for (int n = 0; n < 2; n++)
    begin
      c = probe_ctrl_i[n*8 +: 8];
      o = c[2] ? lv[2] : lv[n];
      w = c[2] ? l[2] : l[n];
      if (!o && w && c[0] && c[4] && (c[1] || !es[n*8+1]))
      begin
        es[n*8+1] = 1'b1;
        epos[2*n] = p;
        ecnt = ecnt + 16'(n == 0);
      end
      if (o && !w && c[0] && c[5] && (c[1] || !es[n*8+2]))
      begin
        es[n*8+2] = 1'b1;
        epos[2*n+1] = p;
      end
    end
    pos_feedback_i = p;
    lvl = l;
    lv = l;
    repeat (7) @(posedge core_clk_i);
    #1;
  endtask : drive
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // ****
  // Main sequence: reset values, unknown index, then mode table with random levels
  // ****
  initial
  begin
    void'($urandom(32'he726));
    repeat (5) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    check_all();
    rd(16'h60be, 32'h0, 1'b1);
    for (int i = 0; i < 48; i++)
    begin
      if (i % 8 == 0)
        setc(CTAB[i/8]);
      drive(3'($urandom_range(7, 0)));
      check_all();
    end
    // Mid-run reset with the pins parked low, so no false edge follows release
    drive(3'b000);
    rst_i = 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    es = '0;
    es[0] = probe_ctrl_i[0];
    es[8] = probe_ctrl_i[8];
    ecnt = '0;
    epos = '{default: '0};
    check_all();
    finish_test();
  end
endmodule : tb_top
